// file: rtl/lif_pkg.sv
// Package of constants for the line interface mode and alarm control block
package lif_pkg;
	localparam int NCH = 4;
	localparam int AW = 8;
	localparam int DW = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_INT_STATUS = 8'h08;
	localparam logic [7:0] OFF_INT_CLEAR = 8'h0c;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h10;

	// Field positions: four-bit groups with one bit per channel, and the single host mode bit
	localparam int CFG_E3_LSB = 0;
	localparam int CFG_STS1_LSB = 4;
	localparam int CFG_AOS_LSB = 8;
	localparam int ST_DMO_LSB = 0;
	localparam int ST_LOS_LSB = 4;
	localparam int ST_LOL_LSB = 8;
	localparam int ST_HOST_BIT = 12;
	localparam int EV_W = 12;

	// Values after reset
	localparam logic [11:0] CONFIG_RST = 12'h000;
	localparam logic [11:0] INT_EN_RST = 12'h000;
	localparam logic [11:0] INT_ST_RST = 12'h000;

	// Counts in transmit clock, recovered clock or reference clock periods
	localparam logic [7:0] DMO_PERIODS = 8'h80;
	localparam logic [7:0] LOS_ZEROS_E3 = 8'h20;
	localparam logic [7:0] LOS_ZEROS_DS3 = 8'haf;
	localparam int LOL_WINDOW_INT = 400;
	localparam int LOL_TOL_PER_MILLE = 5;
	localparam logic [9:0] LOL_WINDOW = 10'(LOL_WINDOW_INT);
	localparam logic [9:0] LOL_TOL = 10'(LOL_WINDOW_INT * LOL_TOL_PER_MILLE / 1000);
endpackage

// file: rtl/lif_drive_mon.sv
// Drive monitor alarm and transmit line pattern for one channel
module lif_drive_mon (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_tx_clock,
	input wire logic i_mon_tip,
	input wire logic i_mon_ring,
	input wire logic i_all_ones,
	input wire logic i_tx_pos,
	input wire logic i_tx_neg,
	output logic o_alarm,
	output logic o_line_tip,
	output logic o_line_ring
);
	logic tx_clk_d_ff;
	logic [7:0] idle_cnt_ff;
	logic alarm_ff;
	logic pol_ff;
	logic tip_ff;
	logic ring_ff;
	wire tx_edge = i_tx_clock & ~tx_clk_d_ff;
	// Monitor taps idle high; a mark pulls one of them low
	wire mon_pulse = ~(i_mon_tip & i_mon_ring);
	wire idle_full = (idle_cnt_ff == lif_pkg::DMO_PERIODS);
	wire [7:0] nxt_idle_cnt = mon_pulse ? 8'h00 :
		(tx_edge && !idle_full) ? idle_cnt_ff + 8'h01 : idle_cnt_ff;
	wire nxt_alarm = mon_pulse ? 1'b0 : (alarm_ff | idle_full);
	wire nxt_pol = (i_all_ones && tx_edge) ? ~pol_ff : pol_ff;
	wire nxt_tip = i_all_ones ? nxt_pol : i_tx_pos;
	wire nxt_ring = i_all_ones ? ~nxt_pol : i_tx_neg;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_clk_d_ff <= 1'b0;
			idle_cnt_ff <= 8'h00;
			alarm_ff <= 1'b0;
			pol_ff <= 1'b0;
			tip_ff <= 1'b0;
			ring_ff <= 1'b0;
		end else begin
			tx_clk_d_ff <= i_tx_clock;
			idle_cnt_ff <= nxt_idle_cnt;
			alarm_ff <= nxt_alarm;
			pol_ff <= nxt_pol;
			tip_ff <= nxt_tip;
			ring_ff <= nxt_ring;
		end
	end

	assign o_alarm = alarm_ff;
	assign o_line_tip = tip_ff;
	assign o_line_ring = ring_ff;
endmodule

// file: rtl/lif_lock_mon.sv
// Loss of lock detector comparing recovered and reference clock edge counts
module lif_lock_mon (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_ref_edge,
	input wire logic i_rec_edge,
	output logic o_lock_loss
);
	logic [9:0] ref_cnt_ff;
	logic [9:0] rec_cnt_ff;
	logic lol_ff;
	wire rec_max = (rec_cnt_ff == 10'h3ff);
	wire [9:0] rec_sum = (i_rec_edge && !rec_max) ? rec_cnt_ff + 10'h001 : rec_cnt_ff;
	wire win_end = i_ref_edge && (ref_cnt_ff == lif_pkg::LOL_WINDOW - 10'h001);
	// Outside the window by more than the tolerance means the clocks deviate
	wire too_fast = rec_sum > (lif_pkg::LOL_WINDOW + lif_pkg::LOL_TOL);
	wire too_slow = rec_sum < (lif_pkg::LOL_WINDOW - lif_pkg::LOL_TOL);
	wire nxt_lol = win_end ? (too_fast | too_slow) : lol_ff;
	wire [9:0] nxt_ref_cnt = win_end ? 10'h000 :
		i_ref_edge ? ref_cnt_ff + 10'h001 : ref_cnt_ff;
	wire [9:0] nxt_rec_cnt = win_end ? 10'h000 : rec_sum;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_cnt_ff <= 10'h000;
			rec_cnt_ff <= 10'h000;
			lol_ff <= 1'b0;
		end else begin
			ref_cnt_ff <= nxt_ref_cnt;
			rec_cnt_ff <= nxt_rec_cnt;
			lol_ff <= nxt_lol;
		end
	end

	assign o_lock_loss = lol_ff;
endmodule

// file: rtl/lif_mode_alarm.sv
// Top of the four-channel mode selection and alarm block with APB registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
module lif_mode_alarm (
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Mode and per-channel configuration pins
	input wire logic i_config_source_select,
	input wire logic [3:0] i_e3_rate_select,
	input wire logic [3:0] i_sts1_vs_ds3_select,
	input wire logic [3:0] i_transmit_all_ones_select,
	// Transmit side
	input wire logic [3:0] i_transmit_clock_in,
	input wire logic [3:0] i_tx_pos,
	input wire logic [3:0] i_tx_neg,
	input wire logic [3:0] i_monitor_tip_input,
	input wire logic [3:0] i_monitor_ring_input,
	// Receive side
	input wire logic [3:0] i_lock_reference_clock,
	input wire logic [3:0] i_recovered_clock,
	input wire logic [3:0] i_rx_pos,
	input wire logic [3:0] i_rx_neg,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Line and alarm outputs
	output logic [3:0] o_line_out_tip,
	output logic [3:0] o_line_out_ring,
	output logic [3:0] o_drive_monitor_alarm,
	output logic [3:0] o_receive_signal_loss_flag,
	output logic [3:0] o_receive_lock_loss_flag,
	output logic o_irq
);
	// Register state
	logic [11:0] config_ff;
	logic [11:0] int_status_ff;
	logic [11:0] int_enable_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;

	// Alarm history for event detection
	logic [11:0] alarm_d_ff;

	// Edge detection of sampled clocks
	logic [3:0] rec_clk_d_ff;
	logic [3:0] ref_clk_d_ff;

	// Signal loss flags, one flop per channel
	wire [3:0] los_flag;

	// Per-channel effective configuration and alarms
	wire host_mode = i_config_source_select;
	wire [3:0] eff_e3;
	wire [3:0] eff_sts1;
	wire [3:0] eff_all_ones;
	wire [3:0] dmo;
	wire [3:0] lock_loss_condition;
	wire [3:0] rec_edge;
	wire [3:0] ref_edge;
	wire [11:0] alarm_now;
	wire [11:0] events;

	// Host register fields
	wire [3:0] reg_e3 = config_ff[lif_pkg::CFG_E3_LSB +: 4];
	wire [3:0] reg_sts1 = config_ff[lif_pkg::CFG_STS1_LSB +: 4];
	wire [3:0] reg_all_ones = config_ff[lif_pkg::CFG_AOS_LSB +: 4];

	// Host mode takes the register fields, hardware mode the pins
	assign eff_e3 = host_mode ? reg_e3 : i_e3_rate_select;
	assign eff_sts1 = host_mode ? reg_sts1 : i_sts1_vs_ds3_select;
	assign eff_all_ones = host_mode ? reg_all_ones : i_transmit_all_ones_select;

	assign rec_edge = i_recovered_clock & ~rec_clk_d_ff;
	assign ref_edge = i_lock_reference_clock & ~ref_clk_d_ff;

	genvar ch;
	generate
		for (ch = 0; ch < lif_pkg::NCH; ch = ch + 1) begin : g_ch
			logic [7:0] zero_cnt_ff;
			logic los_bit_ff;
			wire rx_mark = i_rx_pos[ch] | i_rx_neg[ch];
			// E3 uses the short zero run; DS3 and STS-1 share the long one
			wire [7:0] los_limit = eff_e3[ch] ? lif_pkg::LOS_ZEROS_E3 :
				lif_pkg::LOS_ZEROS_DS3;
			wire zero_full = (zero_cnt_ff >= los_limit);
			wire count_zero = rec_edge[ch] && !rx_mark && !zero_full;
			wire [7:0] nxt_zero_cnt = (rec_edge[ch] && rx_mark) ? 8'h00 :
				count_zero ? zero_cnt_ff + 8'h01 : zero_cnt_ff;
			// Declared while the zero run reaches the limit, cleared by a mark
			wire nxt_los = (rec_edge[ch] && rx_mark) ? 1'b0 :
				(los_bit_ff | zero_full);

			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					zero_cnt_ff <= 8'h00;
					los_bit_ff <= 1'b0;
				end else begin
					zero_cnt_ff <= nxt_zero_cnt;
					los_bit_ff <= nxt_los;
				end
			end
			assign los_flag[ch] = los_bit_ff;

			lif_drive_mon u_drive_mon (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_tx_clock(i_transmit_clock_in[ch]),
				.i_mon_tip(i_monitor_tip_input[ch]),
				.i_mon_ring(i_monitor_ring_input[ch]),
				.i_all_ones(eff_all_ones[ch]),
				.i_tx_pos(i_tx_pos[ch]),
				.i_tx_neg(i_tx_neg[ch]),
				.o_alarm(dmo[ch]),
				.o_line_tip(o_line_out_tip[ch]),
				.o_line_ring(o_line_out_ring[ch])
			);

			lif_lock_mon u_lock_mon (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_ref_edge(ref_edge[ch]),
				.i_rec_edge(rec_edge[ch]),
				.o_lock_loss(lock_loss_condition[ch])
			);
		end
	endgenerate

	// Alarm levels and their rising edges as interrupt events
	assign alarm_now = {lock_loss_condition, los_flag, dmo};
	assign events = alarm_now & ~alarm_d_ff;

	// APB decode: answer in the first cycle of the access phase
	wire setup = i_psel & ~i_penable;
	wire access_done = i_psel & i_penable & pready_ff;
	wire wr_done = access_done & i_pwrite;
	wire hit_config = (i_paddr == lif_pkg::OFF_CONFIG);
	wire hit_status = (i_paddr == lif_pkg::OFF_STATUS);
	wire hit_int_status = (i_paddr == lif_pkg::OFF_INT_STATUS);
	wire hit_int_clear = (i_paddr == lif_pkg::OFF_INT_CLEAR);
	wire hit_int_enable = (i_paddr == lif_pkg::OFF_INT_ENABLE);
	wire hit_any = hit_config | hit_status | hit_int_status | hit_int_clear | hit_int_enable;
	// Read-only and write-only registers refuse the other direction
	wire bad_dir = (i_pwrite && (hit_status || hit_int_status)) ||
		(!i_pwrite && hit_int_clear);
	// Configuration register refuses writes in hardware mode; reads still answer
	wire cfg_locked = i_pwrite && hit_config && !host_mode;
	wire nxt_pslverr = setup ? (!hit_any || bad_dir || cfg_locked) : 1'b0;
	wire wr_ok = wr_done && !pslverr_ff;

	// Live effective rate selects sit above the mode bit
	wire [31:0] status_word = {11'h000, eff_sts1, eff_e3, host_mode, lock_loss_condition, los_flag, dmo};
	wire [31:0] rd_mux = hit_config ? {20'h00000, config_ff} :
		hit_status ? status_word :
		hit_int_status ? {20'h00000, int_status_ff} :
		hit_int_enable ? {20'h00000, int_enable_ff} : 32'h00000000;
	wire [31:0] nxt_prdata = (setup && !i_pwrite) ? rd_mux : prdata_ff;

	wire [11:0] nxt_config = (wr_ok && hit_config) ? i_pwdata[11:0] : config_ff;
	wire [11:0] nxt_int_enable = (wr_ok && hit_int_enable) ? i_pwdata[11:0] :
		int_enable_ff;
	wire [11:0] clr_mask = (wr_ok && hit_int_clear) ? i_pwdata[11:0] : 12'h000;
	// A new event wins over a clear in the same cycle
	wire [11:0] nxt_int_status = (int_status_ff & ~clr_mask) | events;
	wire nxt_irq = |(nxt_int_status & int_enable_ff);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			config_ff <= lif_pkg::CONFIG_RST;
			int_enable_ff <= lif_pkg::INT_EN_RST;
			int_status_ff <= lif_pkg::INT_ST_RST;
			irq_ff <= 1'b0;
		end else begin
			config_ff <= nxt_config;
			int_enable_ff <= nxt_int_enable;
			int_status_ff <= nxt_int_status;
			irq_ff <= nxt_irq;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= setup;
			pslverr_ff <= nxt_pslverr;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alarm_d_ff <= 12'h000;
			rec_clk_d_ff <= 4'h0;
			ref_clk_d_ff <= 4'h0;
		end else begin
			alarm_d_ff <= alarm_now;
			rec_clk_d_ff <= i_recovered_clock;
			ref_clk_d_ff <= i_lock_reference_clock;
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_drive_monitor_alarm = dmo;
	assign o_receive_signal_loss_flag = los_flag;
	assign o_receive_lock_loss_flag = lock_loss_condition;
	assign o_irq = irq_ff;
endmodule

// file: test/lif_props.sv
// Checker of port-level relations for the mode and alarm block
module lif_props (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_config_source_select,
	input wire logic [3:0] i_transmit_all_ones_select,
	input wire logic [3:0] i_tx_pos,
	input wire logic [3:0] i_monitor_tip_input,
	input wire logic [3:0] i_monitor_ring_input,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [3:0] o_line_out_tip,
	input wire logic [3:0] o_line_out_ring,
	input wire logic [3:0] o_drive_monitor_alarm
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence hw_aos_s;
		(!i_config_source_select && i_transmit_all_ones_select[0])[*3];
	endsequence
	pready_next_a: assert property (setup_s |=> o_pready)
		else $error("no ready after setup");
	pready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	err_valid_a: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	unmapped_err_a: assert property (setup_s ##0 (i_paddr > 8'h10) |=> o_pslverr)
		else $error("unmapped access not refused");
	hw_cfg_err_a: assert property (setup_s ##0 (i_pwrite && i_paddr == 8'h00 && !i_config_source_select) |=> o_pslverr)
		else $error("config write accepted in hardware mode");
	aos_compl_a: assert property (hw_aos_s |-> o_line_out_tip[0] != o_line_out_ring[0])
		else $error("all-ones rails not complementary");
	data_copy_a: assert property ((!i_config_source_select && !i_transmit_all_ones_select[0])[*2]
		|-> o_line_out_tip[0] == $past(i_tx_pos[0]))
		else $error("line does not follow data");
	alarm_rise_a: assert property ($rose(o_drive_monitor_alarm[0])
		|-> $past(i_monitor_tip_input[0] && i_monitor_ring_input[0]))
		else $error("alarm rose after a mark");
	alarm_fall_a: assert property ((o_drive_monitor_alarm[0]
		&& !(i_monitor_tip_input[0] && i_monitor_ring_input[0])) |=> !o_drive_monitor_alarm[0])
		else $error("alarm held after a mark");
endmodule

// file: test/lif_line_partner.sv
// Line taps, clock sources and receive data of the far side
module lif_line_partner (
	input wire logic i_clock,
	input wire logic [3:0] i_line_tip,
	input wire logic [3:0] i_line_ring,
	input wire logic [3:0] i_rx_quiet,
	input wire logic [3:0] i_rec_fast,
	output logic [3:0] o_tx_clock,
	output logic [3:0] o_ref_clock,
	output logic [3:0] o_rec_clock,
	output logic [3:0] o_rx_pos,
	output logic [3:0] o_rx_neg,
	output logic [3:0] o_mon_tip,
	output logic [3:0] o_mon_ring
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	logic [1:0] fph = 2'h0;
	logic alt = 1'b0;
	always @(posedge i_clock) begin
		ph <= ph + 2'h1;
		fph <= (fph == 2'h2) ? 2'h0 : fph + 2'h1;
		if (ph == 2'h3) begin
			alt <= ~alt;
		end
	end
	assign o_tx_clock = {4{ph[1]}};
	assign o_ref_clock = {4{ph[1]}};
	// Fast channels run a third above the reference, far outside tolerance
	assign o_rec_clock = (i_rec_fast & {4{fph == 2'h0}}) | (~i_rec_fast & {4{ph[1]}});
	assign o_rx_pos = ~i_rx_quiet & {4{alt}};
	assign o_rx_neg = ~i_rx_quiet & {4{~alt}};
	// Taps are pulled up; a driven mark pulls them low
	assign o_mon_tip = ~i_line_tip;
	assign o_mon_ring = ~i_line_ring;
endmodule

// file: test/lif_mode_alarm_test.sv
// Self-checking bench of the mode and alarm block
module lif_mode_alarm_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, host = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
	logic [3:0] e3 = 0, sts = 0, aos = 0, txp = 0, txn = 0, quiet = 0, fast = 0;
	logic [3:0] txc, refc, recc, rxp, rxn, mtip, mring, ltip, lring, dmo, signal_loss_condition, lock_loss_condition;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	int errors = 0, total_checks = 0, n, m;
	always #50 clk = ~clk;
	lif_mode_alarm lif_mode_alarm_i (.i_clock(clk), .i_rst_n(rst_n), .i_config_source_select(host),
		.i_e3_rate_select(e3), .i_sts1_vs_ds3_select(sts), .i_transmit_all_ones_select(aos),
		.i_transmit_clock_in(txc), .i_tx_pos(txp), .i_tx_neg(txn), .i_monitor_tip_input(mtip),
		.i_monitor_ring_input(mring), .i_lock_reference_clock(refc), .i_recovered_clock(recc),
		.i_rx_pos(rxp), .i_rx_neg(rxn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_line_out_tip(ltip), .o_line_out_ring(lring),
		.o_drive_monitor_alarm(dmo), .o_receive_signal_loss_flag(signal_loss_condition),
		.o_receive_lock_loss_flag(lock_loss_condition), .o_irq(irq));
	lif_line_partner lif_line_partner_i (.i_clock(clk), .i_line_tip(ltip), .i_line_ring(lring),
		.i_rx_quiet(quiet), .i_rec_fast(fast), .o_tx_clock(txc), .o_ref_clock(refc),
		.o_rec_clock(recc), .o_rx_pos(rxp), .o_rx_neg(rxn), .o_mon_tip(mtip), .o_mon_ring(mring));
	task automatic test_done;
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
		if (k >= 50) begin
			chk("apb ready", 1, 0);
		end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return dmo[0];
			1: return signal_loss_condition[0];
			2: return lock_loss_condition[0];
			default: return irq;
		endcase
	endfunction
	task automatic wait_lvl(input int s, input logic lv, input int lim);
		n = 0;
		while (pick(s) !== lv && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic rails(input int cyc);
		logic p;
		n = 0;
		m = 0;
		p = ltip[0];
		repeat (cyc) begin
			@(posedge clk);
			n += (ltip[0] !== p);
			m += (ltip[0] | lring[0]);
			p = ltip[0];
		end
	endtask
	initial begin
		#2000000;
		chk("watchdog", 0, 1);
		test_done;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		apb(0, 8'h00, 0); chk("config reset", 0, rd);
		apb(0, 8'h10, 0); chk("enable reset", 0, rd);
		apb(0, 8'h20, 0); chk("unmapped err", 1, err);
		apb(1, 8'h00, 32'hfff); chk("hw config err", 1, err);
		txp <= 4'h5;
		txn <= 4'ha;
		repeat (3) @(posedge clk);
		chk("data tip", 4'h5, ltip);
		chk("data ring", 4'ha, lring);
		txp <= 0;
		txn <= 0;
		@(posedge clk);
		wait_lvl(0, 1, 800); chk("alarm delay", 1, n >= 382 && n <= 650);
		aos <= 4'h1;
		repeat (4) @(posedge clk);
		rails(40); chk("ones rate", 10, n);
		chk("ones marks", 40, m);
		chk("alarm state", 4'he, dmo);
		host <= 1;
		repeat (3) @(posedge clk);
		rails(20); chk("pin ignored", 0, m);
		apb(0, 8'h04, 0); chk("host bit", 1, rd[12]);
		apb(1, 8'h00, 32'h100); chk("host write", 0, err);
		repeat (3) @(posedge clk);
		rails(40); chk("host ones", 10, n);
		apb(1, 8'h00, 0);
		host <= 0;
		aos <= 0;
		for (int i = 0; i < 3; i++) begin
			e3 <= {3'h0, i == 0};
			sts <= {3'h0, i == 2};
			quiet <= 4'h1;
			@(posedge clk);
			wait_lvl(1, 1, 900);
			chk("loss delay", 1, (i == 0) ? (n >= 120 && n <= 140) : (n >= 690 && n <= 715));
			quiet <= 0;
			repeat (12) @(posedge clk);
			chk("loss clear", 0, signal_loss_condition[0]);
			apb(0, 8'h04, 0); chk("rate select", {3'h0, i == 2, 3'h0, i == 0}, rd[20:13]);
		end
		apb(1, 8'h10, 0);
		fast <= 4'h1;
		wait_lvl(2, 1, 3400); chk("lock loss", 1, lock_loss_condition[0]);
		chk("lock kept", 0, lock_loss_condition[1]);
		chk("irq masked", 0, irq);
		apb(1, 8'h10, 32'h100);
		repeat (2) @(posedge clk);
		chk("irq on", 1, irq);
		apb(0, 8'h08, 0); chk("event bit", 1, rd[8]);
		fast <= 0;
		wait_lvl(2, 0, 3400); chk("lock back", 0, lock_loss_condition[0]);
		apb(1, 8'h0c, 32'h100);
		repeat (2) @(posedge clk);
		chk("irq off", 0, irq);
		apb(0, 8'h08, 0); chk("event clear", 0, rd[8]);
		test_done;
	end
endmodule
bind lif_mode_alarm lif_props lif_props_i (.*);
